// [logic/fsr_pkg.sv]
// status word definitions: bit positions, command codes, read modes, result codes.
// assumes a single 200 MHz clock domain with an active-low asynchronous reset.
package fsr_pkg;
	// ----------------------------------------
	// status word bit positions
	// ----------------------------------------
	localparam int unsigned STAT_W = 8;
	localparam int unsigned BIT_IDLE = 7;
	localparam int unsigned BIT_ERS_SUSP = 6;
	localparam int unsigned BIT_ERS_FAIL = 5;
	localparam int unsigned BIT_PRG_FAIL = 4;
	localparam int unsigned BIT_VPE_FAULT = 3;
	localparam int unsigned BIT_PRG_SUSP = 2;
	localparam int unsigned BIT_PROT_FAULT = 1;
	localparam int unsigned BIT_RSVD = 0;
	localparam logic [7:0] STAT_RESET = 8'h80;
	localparam logic [7:0] STAT_OE_BUSY = 8'h80;
	localparam logic [7:0] STAT_OE_IDLE = 8'hFF;

	// ----------------------------------------
	// command codes from the command decoder
	// ----------------------------------------
	typedef enum logic [3:0] {
		FSR_CMD_NONE,
		FSR_CMD_READ_STATUS,
		FSR_CMD_READ_ARRAY,
		FSR_CMD_CLEAR_STATUS,
		FSR_CMD_PROGRAM,
		FSR_CMD_ERASE,
		FSR_CMD_PROTECT,
		FSR_CMD_UNPROTECT,
		FSR_CMD_SUSPEND,
		FSR_CMD_RESUME,
		FSR_CMD_OTHER
	} fsr_cmd_e;

	// ----------------------------------------
	// operation outcome from the controller
	// ----------------------------------------
	typedef enum logic [2:0] {
		FSR_RES_OK,
		FSR_RES_CELL_FAIL,
		FSR_RES_VPE_LOW,
		FSR_RES_PROTECTED,
		FSR_RES_BAD_SEQ
	} fsr_res_e;

	// kind of operation that the controller is running
	typedef enum logic [1:0] {
		FSR_OP_PROGRAM,
		FSR_OP_ERASE,
		FSR_OP_PROTECT,
		FSR_OP_UNPROTECT
	} fsr_op_e;

	typedef enum logic [1:0] {
		FSR_BUS_ARRAY_CFG,
		FSR_BUS_STATUS_ASYNC
	} fsr_bus_e;
endpackage : fsr_pkg

// [logic/fsr_bus_track.sv]
// read bus tracking: detects the start of a fresh status read.
// assumes chip and output enables already sampled into the clock domain.
`timescale 1ns/1ps
module fsr_bus_track
	import fsr_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic chip_en_b_i,
	input wire logic out_en_b_i,
	output logic read_active_o,
	output logic refresh_o
);
	typedef struct packed {
		logic ce_d;
		logic oe_d;
	} fsr_trk_s;

	fsr_trk_s st;
	fsr_trk_s next_st;

	always_comb begin
		next_st.ce_d = ~chip_en_b_i;
		next_st.oe_d = ~out_en_b_i;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign read_active_o = ~chip_en_b_i & ~out_en_b_i;
	// a new access begins on the first cycle that both enables are active, after a cycle when they were not both active
	assign refresh_o = read_active_o & ~(st.ce_d & st.oe_d);
endmodule : fsr_bus_track

// [logic/fsr_flag_update.sv]
// next-value computation for the sticky error and suspend flags.
// assumes the outcome strobe is a one-cycle pulse.
`timescale 1ns/1ps
module fsr_flag_update
	import fsr_pkg::*;
(
	input wire logic [7:0] flags_i,
	input wire logic done_i,
	input wire fsr_res_e result_i,
	input wire fsr_op_e op_i,
	input wire logic clear_i,
	input wire logic vpe_attempt_i,
	input wire logic prog_paused_i,
	input wire logic erase_paused_i,
	input wire logic resume_i,
	output logic [7:0] flags_o
);
	logic is_erase;
	always_comb begin
		flags_o = flags_i;
		is_erase = (op_i == FSR_OP_ERASE) || (op_i == FSR_OP_UNPROTECT);
		if (clear_i) begin
			flags_o[BIT_ERS_FAIL] = 1'b0;
			flags_o[BIT_PRG_FAIL] = 1'b0;
			flags_o[BIT_VPE_FAULT] = 1'b0;
			flags_o[BIT_PROT_FAULT] = 1'b0;
		end
		if (resume_i) begin
			flags_o[BIT_ERS_SUSP] = 1'b0;
			flags_o[BIT_PRG_SUSP] = 1'b0;
		end
		if (erase_paused_i) begin
			flags_o[BIT_ERS_SUSP] = 1'b1;
		end
		if (prog_paused_i) begin
			flags_o[BIT_PRG_SUSP] = 1'b1;
		end
		if (vpe_attempt_i) begin
			flags_o[BIT_VPE_FAULT] = 1'b1;
		end
		// setting wins over a clear in the same cycle
		if (done_i) begin
			case (result_i)
				FSR_RES_CELL_FAIL: begin
					if (is_erase) flags_o[BIT_ERS_FAIL] = 1'b1;
					else flags_o[BIT_PRG_FAIL] = 1'b1;
				end
				FSR_RES_VPE_LOW: begin
					if (is_erase) flags_o[BIT_ERS_FAIL] = 1'b1;
					else flags_o[BIT_PRG_FAIL] = 1'b1;
					flags_o[BIT_VPE_FAULT] = 1'b1;
				end
				FSR_RES_PROTECTED: begin
					if (is_erase) flags_o[BIT_ERS_FAIL] = 1'b1;
					else flags_o[BIT_PRG_FAIL] = 1'b1;
					flags_o[BIT_PROT_FAULT] = 1'b1;
				end
				FSR_RES_BAD_SEQ: begin
					flags_o[BIT_ERS_FAIL] = 1'b1;
					flags_o[BIT_PRG_FAIL] = 1'b1;
				end
				default: begin
				end
			endcase
		end
		flags_o[BIT_RSVD] = 1'b0;
		flags_o[BIT_IDLE] = 1'b0;
	end
endmodule : fsr_flag_update

// [logic/fsr_status.sv]
// status word reporting for the program/erase controller.
// assumes a command decoder and controller in the same clock domain.
`timescale 1ns/1ps
module fsr_status
	import fsr_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic chip_en_b_i,
	input wire logic out_en_b_i,
	input wire logic sync_burst_cfg_i,
	input wire logic cmd_valid_i,
	input wire fsr_cmd_e cmd_i,
	input wire logic ctrl_busy_i,
	input wire logic ctrl_done_i,
	input wire fsr_res_e ctrl_result_i,
	input wire fsr_op_e ctrl_op_i,
	input wire logic ctrl_paused_i,
	input wire logic program_erase_enable_pin_i,
	input wire logic [15:0] array_data_i,
	output logic [15:0] data_o,
	output logic [15:0] data_oe_o,
	output logic status_mode_o,
	output logic burst_enable_o,
	output logic [7:0] operation_status_word_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {
		FSR_ST_IDLE,
		FSR_ST_RUN,
		FSR_ST_SUSP_WAIT,
		FSR_ST_PAUSED
	} fsr_ctl_e;

	typedef struct packed {
		fsr_ctl_e ctl;
		fsr_bus_e bus;
		fsr_op_e op;
		logic [7:0] flags;
		logic [7:0] shown;
		logic [15:0] data;
		logic [15:0] oe;
	} fsr_state_s;

	fsr_state_s st;
	fsr_state_s next_st;

	logic read_active;
	logic refresh;
	logic [7:0] next_flags;
	logic clear_cmd;
	logic resume_cmd;
	logic op_cmd;
	logic vpe_attempt;
	logic prog_paused;
	logic erase_paused;
	logic idle_now;

	function automatic logic is_op_cmd(input fsr_cmd_e c);
		is_op_cmd = (c == FSR_CMD_PROGRAM) || (c == FSR_CMD_ERASE) ||
			(c == FSR_CMD_PROTECT) || (c == FSR_CMD_UNPROTECT);
	endfunction : is_op_cmd

	function automatic fsr_op_e op_of(input fsr_cmd_e c);
		case (c)
			FSR_CMD_ERASE: op_of = FSR_OP_ERASE;
			FSR_CMD_PROTECT: op_of = FSR_OP_PROTECT;
			FSR_CMD_UNPROTECT: op_of = FSR_OP_UNPROTECT;
			default: op_of = FSR_OP_PROGRAM;
		endcase
	endfunction : op_of

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	fsr_bus_track u_track (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.chip_en_b_i(chip_en_b_i),
		.out_en_b_i(out_en_b_i),
		.read_active_o(read_active),
		.refresh_o(refresh)
	);

	assign clear_cmd = cmd_valid_i && (cmd_i == FSR_CMD_CLEAR_STATUS);
	assign resume_cmd = cmd_valid_i && (cmd_i == FSR_CMD_RESUME) && (st.ctl == FSR_ST_PAUSED);
	assign op_cmd = cmd_valid_i && is_op_cmd(cmd_i);
	assign vpe_attempt = op_cmd && !program_erase_enable_pin_i;
	assign prog_paused = (st.ctl == FSR_ST_SUSP_WAIT) && ctrl_paused_i &&
		(st.op != FSR_OP_ERASE);
	assign erase_paused = (st.ctl == FSR_ST_SUSP_WAIT) && ctrl_paused_i &&
		(st.op == FSR_OP_ERASE);

	fsr_flag_update u_flags (
		.flags_i(st.flags),
		.done_i(ctrl_done_i),
		.result_i(ctrl_result_i),
		.op_i(st.op),
		.clear_i(clear_cmd),
		.vpe_attempt_i(vpe_attempt),
		.prog_paused_i(prog_paused),
		.erase_paused_i(erase_paused),
		.resume_i(resume_cmd),
		.flags_o(next_flags)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.flags = next_flags;
		case (st.ctl)
			FSR_ST_IDLE: begin
				if (op_cmd) begin
					next_st.ctl = FSR_ST_RUN;
					next_st.op = op_of(cmd_i);
				end
			end
			FSR_ST_RUN: begin
				if (ctrl_done_i) begin
					next_st.ctl = FSR_ST_IDLE;
				end else if (cmd_valid_i && cmd_i == FSR_CMD_SUSPEND) begin
					next_st.ctl = FSR_ST_SUSP_WAIT;
				end
			end
			FSR_ST_SUSP_WAIT: begin
				if (ctrl_done_i) begin
					next_st.ctl = FSR_ST_IDLE;
				end else if (ctrl_paused_i) begin
					next_st.ctl = FSR_ST_PAUSED;
				end
			end
			FSR_ST_PAUSED: begin
				if (resume_cmd) begin
					next_st.ctl = FSR_ST_RUN;
				end
			end
			default: begin
				next_st.ctl = FSR_ST_IDLE;
			end
		endcase

		if (cmd_valid_i) begin
			if (cmd_i == FSR_CMD_READ_STATUS || op_cmd || resume_cmd) begin
				next_st.bus = FSR_BUS_STATUS_ASYNC;
			end else if (cmd_i == FSR_CMD_READ_ARRAY) begin
				next_st.bus = FSR_BUS_ARRAY_CFG;
			end
		end

		idle_now = (next_st.ctl == FSR_ST_IDLE) || (next_st.ctl == FSR_ST_PAUSED);
		if (refresh) begin
			next_st.shown = next_flags;
			next_st.shown[BIT_IDLE] = idle_now;
		end else if (!read_active) begin
			// outside an access the word tracks live state
			next_st.shown = next_flags;
			next_st.shown[BIT_IDLE] = idle_now;
		end

		// status on lower lines at any address
		if (next_st.bus == FSR_BUS_STATUS_ASYNC) begin
			next_st.data = {8'h00, next_st.shown};
			next_st.oe = read_active ?
				{8'hFF, (next_st.shown[BIT_IDLE] ? STAT_OE_IDLE : STAT_OE_BUSY)} : 16'h0000;
		end else begin
			next_st.data = array_data_i;
			next_st.oe = read_active ? 16'hFFFF : 16'h0000;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st.ctl <= FSR_ST_IDLE;
			st.bus <= FSR_BUS_ARRAY_CFG;
			st.op <= FSR_OP_PROGRAM;
			st.flags <= 8'h00;
			st.shown <= STAT_RESET;
			st.data <= 16'h0000;
			st.oe <= 16'h0000;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign data_o = st.data;
	assign data_oe_o = st.oe;
	assign status_mode_o = (st.bus == FSR_BUS_STATUS_ASYNC);
	assign burst_enable_o = sync_burst_cfg_i && (st.bus == FSR_BUS_ARRAY_CFG);
	assign operation_status_word_o = st.shown;
endmodule : fsr_status

// [test/fsr_host_model.sv]
// host model: status reads over the chip and output enables.
// assumes the device answers within a few clocks of a new access.
`timescale 1ns/1ps
module fsr_host_model (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic hold_i,
	input wire logic [15:0] data_i,
	input wire logic [15:0] oe_i,
	output logic ce_b_o,
	output logic oe_b_o,
	output logic ack_o,
	output logic [15:0] rd_o,
	output logic [15:0] rd_oe_o
);
	logic [2:0] cnt;
	// ----
	// read sequencing
	// ----
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ce_b_o <= 1'b1;
			oe_b_o <= 1'b1;
			ack_o <= 1'b0;
			cnt <= 3'h0;
			rd_o <= 16'h0000;
			rd_oe_o <= 16'h0000;
		end else begin
			ack_o <= 1'b0;
			if (start_i) begin
				ce_b_o <= 1'b0;
				oe_b_o <= 1'b0;
				cnt <= 3'h6;
			end else if (cnt != 3'h0) begin
				cnt <= cnt - 3'h1;
				ack_o <= (cnt == 3'h1);
			// release, then new access to refresh
			end else if (!hold_i && !oe_b_o) begin
				oe_b_o <= 1'b1;
			end else if (oe_b_o) begin
				ce_b_o <= 1'b1;
			end
			// reserved bit and undriven bits masked
			if (!ce_b_o && !oe_b_o) begin
				rd_o <= data_i & oe_i & 16'hFFFE;
				rd_oe_o <= oe_i;
			end
		end
	end
endmodule : fsr_host_model

// [test/fsr_status_properties.sv]
// checker on the status block ports.
// assumes one clock domain and the active-low reset.
`timescale 1ns/1ps
module fsr_status_checker
	import fsr_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic chip_en_b_i,
	input wire logic sync_burst_cfg_i,
	input wire logic cmd_valid_i,
	input wire fsr_cmd_e cmd_i,
	input wire logic ctrl_done_i,
	input wire fsr_res_e ctrl_result_i,
	input wire logic ctrl_paused_i,
	input wire logic program_erase_enable_pin_i,
	input wire logic [15:0] data_o,
	input wire logic [15:0] data_oe_o,
	input wire logic status_mode_o,
	input wire logic burst_enable_o,
	input wire logic [7:0] operation_status_word_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	a_burst_gate: assert property (burst_enable_o == (sync_burst_cfg_i && !status_mode_o))
		else $error("burst enable wrong");
	a_status_entry: assert property (cmd_valid_i && cmd_i inside {FSR_CMD_READ_STATUS,
		FSR_CMD_PROGRAM, FSR_CMD_ERASE, FSR_CMD_PROTECT, FSR_CMD_UNPROTECT} |=> status_mode_o)
		else $error("status mode not entered");
	a_array_exit: assert property (cmd_valid_i && cmd_i == FSR_CMD_READ_ARRAY
		|=> !status_mode_o)
		else $error("array mode not restored");
	a_reset_word: assert property ($rose(rst_b_i) |-> operation_status_word_o == 8'h80)
		else $error("reset word wrong");
	a_oe_shape: assert property (data_oe_o inside {16'h0000, 16'hFF80, 16'hFFFF})
		else $error("bad drive pattern");
	a_idle_drive: assert property (status_mode_o && data_oe_o[7] |->
		data_o[7] == data_oe_o[0])
		else $error("idle bit and drive disagree");
	a_quiet_bus: assert property (chip_en_b_i [*5] |-> data_oe_o == 16'h0000)
		else $error("bus driven while deselected");
	a_clean_done: assert property (chip_en_b_i [*3] ##0 (ctrl_done_i && !cmd_valid_i &&
		ctrl_result_i == FSR_RES_OK && !ctrl_paused_i && operation_status_word_o[6:1] == 6'h00)
		|=> operation_status_word_o == 8'h80)
		else $error("clean completion word wrong");
	a_sticky_err: assert property (chip_en_b_i [*3] ##0
		!(cmd_valid_i && cmd_i == FSR_CMD_CLEAR_STATUS) |=> (operation_status_word_o &
		$past(operation_status_word_o) & 8'h3A) == ($past(operation_status_word_o) & 8'h3A))
		else $error("error flag dropped");
	a_busy_start: assert property (chip_en_b_i [*3] ##0 (cmd_valid_i &&
		cmd_i == FSR_CMD_PROGRAM && program_erase_enable_pin_i &&
		operation_status_word_o == 8'h80) |=> !operation_status_word_o[7])
		else $error("idle flag not lowered");
endmodule : fsr_status_checker
bind fsr_status fsr_status_checker fsr_status_checker_inst (.clock_i, .rst_b_i, .chip_en_b_i,
	.sync_burst_cfg_i, .cmd_valid_i, .cmd_i, .ctrl_done_i, .ctrl_result_i, .ctrl_paused_i,
	.program_erase_enable_pin_i, .data_o, .data_oe_o, .status_mode_o, .burst_enable_o,
	.operation_status_word_o);

// [test/tb.sv]
// testbench for the status block with a host read model.
// assumes commands and outcomes are driven here in place of the decoder.
`timescale 1ns/1ps
module tb
	import fsr_pkg::*;
;
	logic clock_i, rst_b_i, chip_en_b_i, out_en_b_i, sync_burst_cfg_i, cmd_valid_i;
	logic ctrl_busy_i, ctrl_done_i, ctrl_paused_i, program_erase_enable_pin_i;
	logic start_i, hold_i, ack_o, status_mode_o, burst_enable_o;
	fsr_cmd_e cmd_i;
	fsr_res_e ctrl_result_i, res;
	fsr_op_e ctrl_op_i, op;
	logic [15:0] array_data_i, data_o, data_oe_o, rd_o, rd_oe_o, w16, ex;
	logic [7:0] operation_status_word_o;
	int n_errors, n_compared, k;
	integer seed;
	assign w16 = {8'h00, operation_status_word_o};
	fsr_status fsr_status_inst (.clock_i, .rst_b_i, .chip_en_b_i, .out_en_b_i,
		.sync_burst_cfg_i, .cmd_valid_i, .cmd_i, .ctrl_busy_i, .ctrl_done_i, .ctrl_result_i,
		.ctrl_op_i, .ctrl_paused_i, .program_erase_enable_pin_i, .array_data_i, .data_o,
		.data_oe_o, .status_mode_o, .burst_enable_o, .operation_status_word_o);
	fsr_host_model fsr_host_model_inst (.clock_i, .rst_b_i, .start_i, .hold_i,
		.data_i(data_o), .oe_i(data_oe_o), .ce_b_o(chip_en_b_i), .oe_b_o(out_en_b_i),
		.ack_o, .rd_o, .rd_oe_o);
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	function automatic logic [15:0] ew(input fsr_op_e o, input fsr_res_e r);
		logic er;
		er = o inside {FSR_OP_ERASE, FSR_OP_UNPROTECT};
		case (r)
			FSR_RES_CELL_FAIL: ew = er ? 16'h00A0 : 16'h0090;
			FSR_RES_VPE_LOW: ew = er ? 16'h00A8 : 16'h0098;
			FSR_RES_PROTECTED: ew = er ? 16'h00A2 : 16'h0092;
			FSR_RES_BAD_SEQ: ew = 16'h00B0;
			default: ew = 16'h0080;
		endcase
	endfunction : ew
	task end_of_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask : tick
	task send(input fsr_cmd_e c);
		@(posedge clock_i);
		cmd_valid_i <= 1'b1;
		cmd_i <= c;
		@(posedge clock_i);
		cmd_valid_i <= 1'b0;
		tick(2);
	endtask : send
	task finish_op(input fsr_res_e r);
		@(posedge clock_i);
		ctrl_done_i <= 1'b1;
		ctrl_result_i <= r;
		ctrl_busy_i <= 1'b0;
		@(posedge clock_i);
		ctrl_done_i <= 1'b0;
		tick(2);
	endtask : finish_op
	task rd_st(input logic h);
		int i;
		@(posedge clock_i);
		start_i <= 1'b1;
		hold_i <= h;
		@(posedge clock_i);
		start_i <= 1'b0;
		for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge clock_i);
		if (ack_o !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
	endtask : rd_st
	initial begin
		{rst_b_i, cmd_valid_i, ctrl_busy_i, ctrl_done_i, ctrl_paused_i} = 5'h00;
		{start_i, hold_i, sync_burst_cfg_i, program_erase_enable_pin_i} = 4'h1;
		cmd_i = FSR_CMD_NONE;
		ctrl_result_i = FSR_RES_OK;
		ctrl_op_i = FSR_OP_PROGRAM;
		array_data_i = 16'h0000;
		{n_errors, n_compared, seed} = {32'h0, 32'h0, 32'h2};
		tick(20);
		rst_b_i <= 1'b1;
		tick(2);
		chk("reset word", w16, 16'h0080);
		for (k = 0; k < 24; k++) begin
			op = fsr_op_e'(2'($random(seed)));
			res = fsr_res_e'(3'($unsigned($random(seed)) % 5));
			ex = ew(op, res);
			array_data_i <= 16'($random(seed));
			sync_burst_cfg_i <= 1'($random(seed));
			send(FSR_CMD_CLEAR_STATUS);
			program_erase_enable_pin_i <= (res != FSR_RES_VPE_LOW);
			ctrl_op_i <= op;
			ctrl_busy_i <= 1'b1;
			send(fsr_cmd_e'(4'(op) + 4'h4));
			if (res != FSR_RES_VPE_LOW) chk("busy", w16 & 16'h0080, 16'h0000);
			finish_op(res);
			chk("word", w16, ex);
			rd_st(1'b0);
			chk("read", rd_o, ex & 16'hFFFE);
			chk("read oe", rd_oe_o, 16'hFFFF);
			send(FSR_CMD_READ_STATUS);
			chk("sticky", w16, ex);
			send(FSR_CMD_CLEAR_STATUS);
			chk("cleared", w16, 16'h0080);
		end
		for (k = 0; k < 2; k++) begin
			op = k ? FSR_OP_ERASE : FSR_OP_PROGRAM;
			program_erase_enable_pin_i <= 1'b1;
			ctrl_op_i <= op;
			ctrl_busy_i <= 1'b1;
			send(fsr_cmd_e'(4'(op) + 4'h4));
			send(FSR_CMD_SUSPEND);
			chk("suspending", w16 & 16'h0080, 16'h0000);
			ctrl_paused_i <= 1'b1;
			@(posedge clock_i);
			ctrl_paused_i <= 1'b0;
			tick(2);
			chk("suspended", w16, k ? 16'h00C0 : 16'h0084);
			send(FSR_CMD_RESUME);
			chk("resumed", w16 & 16'h00C4, 16'h0000);
			rd_st(1'b1);
			chk("busy oe", rd_oe_o, 16'hFF80);
			chk("busy bus", rd_o, 16'h0000);
			finish_op(FSR_RES_OK);
			chk("held", w16 & 16'h0080, 16'h0000);
			hold_i <= 1'b0;
			tick(4);
			rd_st(1'b0);
			chk("refresh", rd_o, 16'h0080);
		end
		ctrl_op_i <= FSR_OP_ERASE;
		send(FSR_CMD_ERASE);
		send(FSR_CMD_SUSPEND);
		finish_op(FSR_RES_OK);
		chk("suspend done", w16, 16'h0080);
		sync_burst_cfg_i <= 1'b1;
		send(FSR_CMD_READ_ARRAY);
		chk("burst", {15'h0000, burst_enable_o}, 16'h0001);
		rd_st(1'b0);
		chk("array", rd_o, array_data_i & 16'hFFFE);
		program_erase_enable_pin_i <= 1'b0;
		send(FSR_CMD_ERASE);
		rst_b_i <= 1'b0;
		tick(2);
		rst_b_i <= 1'b1;
		tick(2);
		chk("rereset", w16, 16'h0080);
		chk("mode", {15'h0000, status_mode_o}, 16'h0000);
		end_of_test();
	end
endmodule : tb
